// File: src/ppcfg_top.v
// The AXI4-Lite slave port is this design's own decision.
`include "ppcfg_consts.vh"

// Function
// R1: each two-bit pull code selects weak pull-up, pull-down, strong pull-up or no pull.
// R2: row pins 0-3 use register 0x19 and rows 4-7 use 0x1a, lowest pin in bits 1:0.
// R3: column pins 0-3 use register 0x1b and columns 4-7 use 0x1c, lowest pin in bits 1:0.
// R4: register 0x1d holds columns 8, 9 and 10 in bits 1:0, 3:2, 5:4, bits 7:6 reserved.
// R5: register 0x1e holds one read-write polarity bit per input 1-8, input n at bit n-1.
// R6: an input flag is set whenever its pin sits at the selected level, by level.
// R7: an input flag reads one while pending and is cleared by software reading it.
// R8: reserved bits of the pull registers read zero and ignore writes.
module ppcfg_top #(
   parameter ADDR_W = 8,
   parameter INPUTS = 8,
   parameter ROWS = 8,
   parameter COLS = 11
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [ADDR_W-1:0] awaddr,
   input wire [2:0] awprot,
   input wire awvalid,
   output reg awready,
   // axi4-lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   // axi4-lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // axi4-lite read address
   input wire [ADDR_W-1:0] araddr,
   input wire [2:0] arprot,
   input wire arvalid,
   output reg arready,
   // axi4-lite read data
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // general-purpose input pins (row pins 0-7)
   input wire [INPUTS-1:0] general_input,
   // pull resistor enables, rows at 0..ROWS-1, columns above
   output wire [ROWS+COLS-1:0] pull_up_weak,
   output wire [ROWS+COLS-1:0] pull_down,
   output wire [ROWS+COLS-1:0] pull_up_strong,
   // interrupt
   output reg irq
);

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   // pull codes, two bits per pin
   reg [7:0] row_pull_select_low;
   reg [7:0] row_pull_select_high;
   reg [7:0] column_pull_select_low;
   reg [7:0] column_pull_select_mid;
   reg [`PPCFG_COL_HIGH_W-1:0] column_pull_select_high;
   // polarity, pending flags, sticky status and mask
   reg [INPUTS-1:0] input_irq_polarity_low;
   reg [INPUTS-1:0] input_irq_flag;
   reg [INPUTS-1:0] irq_status;
   reg [INPUTS-1:0] irq_mask;

   // write channel capture
   reg aw_got;
   reg w_got;
   reg [ADDR_W-1:0] wr_addr;
   reg [7:0] wr_byte;
   reg wr_lane0;

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------

   // register index of a byte address
   function [5:0] addr_index;
      input [ADDR_W-1:0] a;
      begin
         addr_index = a[`PPCFG_INDEX_MSB:`PPCFG_INDEX_LSB];
      end
   endfunction

   // true when the address hits a register of this block
   function is_mapped;
      input [ADDR_W-1:0] a;
      reg [5:0] idx;
      begin
         idx = a[`PPCFG_INDEX_MSB:`PPCFG_INDEX_LSB];
         is_mapped = 1'b0;
         // upper address bits must be clear, no aliasing
         if ((a >> `PPCFG_DECODE_TOP) == {ADDR_W{1'b0}}) begin
            case (idx)
               `PPCFG_IDX_INPUT_FLAG,
               `PPCFG_IDX_INPUT_LEVEL,
               `PPCFG_IDX_ROW_LOW,
               `PPCFG_IDX_ROW_HIGH,
               `PPCFG_IDX_COL_LOW,
               `PPCFG_IDX_COL_MID,
               `PPCFG_IDX_COL_HIGH,
               `PPCFG_IDX_POLARITY,
               `PPCFG_IDX_IRQ_STATUS,
               `PPCFG_IDX_IRQ_MASK: is_mapped = 1'b1;
               default: is_mapped = 1'b0;
            endcase
         end
      end
   endfunction

   // read value of a register index, unused bits zero
   function [7:0] read_value;
      input [5:0] idx;
      begin
         case (idx)
            // R7: pending flags
            `PPCFG_IDX_INPUT_FLAG: read_value = input_irq_flag;
            `PPCFG_IDX_INPUT_LEVEL: read_value = general_input;
            // R2: row codes
            `PPCFG_IDX_ROW_LOW: read_value = row_pull_select_low;
            `PPCFG_IDX_ROW_HIGH: read_value = row_pull_select_high;
            `PPCFG_IDX_COL_LOW: read_value = column_pull_select_low;
            `PPCFG_IDX_COL_MID: read_value = column_pull_select_mid;
            // R8: reserved bits read zero
            `PPCFG_IDX_COL_HIGH: read_value = {2'b00, column_pull_select_high};
            // R5: polarity read back
            `PPCFG_IDX_POLARITY: read_value = input_irq_polarity_low;
            `PPCFG_IDX_IRQ_STATUS: read_value = irq_status;
            `PPCFG_IDX_IRQ_MASK: read_value = irq_mask;
            default: read_value = 8'h00;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // bus strobes
   // ----------------------------------------------------------------------

   // a write commits once address and data are both held
   wire wr_commit;
   wire wr_ok;
   wire [5:0] wr_idx;
   wire wr_en;
   wire rd_take;
   wire [5:0] rd_idx;
   wire rd_ok;

   assign wr_commit = aw_got & w_got & ~bvalid;
   assign wr_ok = is_mapped(wr_addr);
   assign wr_idx = addr_index(wr_addr);
   // only byte lane 0 carries register bits; other lanes are ignored
   assign wr_en = wr_commit & wr_ok & wr_lane0;
   assign rd_take = arvalid & arready;
   assign rd_idx = addr_index(araddr);
   assign rd_ok = is_mapped(araddr);

   // ----------------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------------

   // address and data may come in either order; one write at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         wr_addr <= {ADDR_W{1'b0}};
         wr_byte <= 8'h00;
         wr_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `PPCFG_RESP_OKAY;
      end else begin
         // reopen only once the last write has been answered
         if (!aw_got && !bvalid && !awready) begin
            awready <= 1'b1;
         end
         if (!w_got && !bvalid && !wready) begin
            wready <= 1'b1;
         end
         if (awvalid && awready) begin
            aw_got <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_got <= 1'b1;
            wready <= 1'b0;
            wr_byte <= wdata[7:0];
            wr_lane0 <= wstrb[0];
         end
         // the write lands at the edge that raises the answer
         if (wr_commit) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? `PPCFG_RESP_OKAY : `PPCFG_RESP_SLVERR;
         end
         // answer stands until the master takes it
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------------

   // data is captured at the address handshake, so a clear-on-read
   // returns the value seen before the clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `PPCFG_RESP_OKAY;
      end else begin
         // one read in flight; reopen after the answer is taken
         if (!rvalid && !arready) begin
            arready <= 1'b1;
         end
         if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_ok ? read_value(rd_idx) : 8'h00};
            rresp <= rd_ok ? `PPCFG_RESP_OKAY : `PPCFG_RESP_SLVERR;
         end
         // data stands until taken
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // pull, polarity and mask registers
   // ----------------------------------------------------------------------

   // software writes; reserved bits never stored
   always @(posedge aclk) begin
      if (!aresetn) begin
         // R1: code 00 at reset, weak pull-up on every pin
         row_pull_select_low <= `PPCFG_RST_PULL;
         row_pull_select_high <= `PPCFG_RST_PULL;
         column_pull_select_low <= `PPCFG_RST_PULL;
         column_pull_select_mid <= `PPCFG_RST_PULL;
         column_pull_select_high <= `PPCFG_RST_COL_HIGH;
         input_irq_polarity_low <= `PPCFG_RST_POLARITY;
         irq_mask <= `PPCFG_RST_IRQ_MASK;
      end else if (wr_en) begin
         case (wr_idx)
            // R2: row pull registers
            `PPCFG_IDX_ROW_LOW: row_pull_select_low <= wr_byte;
            `PPCFG_IDX_ROW_HIGH: row_pull_select_high <= wr_byte;
            // R3: column pull registers
            `PPCFG_IDX_COL_LOW: column_pull_select_low <= wr_byte;
            `PPCFG_IDX_COL_MID: column_pull_select_mid <= wr_byte;
            // R4: upper columns, bits 7:6 dropped
            `PPCFG_IDX_COL_HIGH:
               column_pull_select_high <= wr_byte[`PPCFG_COL_HIGH_W-1:0];
            // R5: polarity bit per input
            `PPCFG_IDX_POLARITY:
               input_irq_polarity_low <= wr_byte[INPUTS-1:0];
            `PPCFG_IDX_IRQ_MASK: irq_mask <= wr_byte[INPUTS-1:0];
            // other indices leave these registers alone
            default: row_pull_select_low <= row_pull_select_low;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // input flags and interrupt
   // ----------------------------------------------------------------------

   wire [INPUTS-1:0] level_hit;
   wire [INPUTS-1:0] rd_clear;
   wire [INPUTS-1:0] w1c;
   wire [INPUTS-1:0] new_event;
   wire [INPUTS-1:0] next_input_irq_flag;
   wire [INPUTS-1:0] next_irq_status;
   wire [INPUTS-1:0] next_irq_mask;

   // R6: level match per input
   assign level_hit = ~(general_input ^ input_irq_polarity_low);
   // R7: clear by reading the flag register
   assign rd_clear = (rd_take && rd_ok && rd_idx == `PPCFG_IDX_INPUT_FLAG) ?
                     {INPUTS{1'b1}} : {INPUTS{1'b0}};
   // R6: a held level wins over the read clear
   assign next_input_irq_flag = (input_irq_flag & ~rd_clear) | level_hit;
   // a flag going pending is the event for the sticky status
   assign new_event = level_hit & ~input_irq_flag;
   // write-one-to-clear on the status register
   assign w1c = (wr_en && wr_idx == `PPCFG_IDX_IRQ_STATUS) ?
                wr_byte[INPUTS-1:0] : {INPUTS{1'b0}};
   // set wins over write-one-to-clear
   assign next_irq_status = (irq_status & ~w1c) | new_event;
   // irq follows a mask write at the same edge, no stale cycle
   assign next_irq_mask = (wr_en && wr_idx == `PPCFG_IDX_IRQ_MASK) ?
                          wr_byte[INPUTS-1:0] : irq_mask;

   // flags, sticky status and the level interrupt
   always @(posedge aclk) begin
      if (!aresetn) begin
         input_irq_flag <= `PPCFG_RST_FLAG;
         irq_status <= `PPCFG_RST_IRQ_STATUS;
         irq <= 1'b0;
      end else begin
         input_irq_flag <= next_input_irq_flag;
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & next_irq_mask);
      end
   end

   // ----------------------------------------------------------------------
   // pull decoders
   // ----------------------------------------------------------------------

   // R2: rows 0-7 packed low, R3: columns 0-7 next, R4: columns 8-10 top
   wire [2*(ROWS+COLS)-1:0] pull_codes;
   assign pull_codes = {column_pull_select_high, column_pull_select_mid,
                        column_pull_select_low, row_pull_select_high,
                        row_pull_select_low};

   // decoder registers its outputs: pins follow a write one edge later
   // R1: per-pin resistor enables
   ppcfg_pull_decode #(
      .PINS(ROWS+COLS)
   ) u_decode (
      .aclk(aclk),
      .aresetn(aresetn),
      .pull_codes(pull_codes),
      .pull_up_weak(pull_up_weak),
      .pull_down(pull_down),
      .pull_up_strong(pull_up_strong)
   );

endmodule // ppcfg_top

// File: src/ppcfg_consts.vh
`ifndef PPCFG_CONSTS_VH
`define PPCFG_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PPCFG_IDX_INPUT_FLAG 6'h13
`define PPCFG_IDX_INPUT_LEVEL 6'h16
`define PPCFG_IDX_ROW_LOW 6'h19
`define PPCFG_IDX_ROW_HIGH 6'h1a
`define PPCFG_IDX_COL_LOW 6'h1b
`define PPCFG_IDX_COL_MID 6'h1c
`define PPCFG_IDX_COL_HIGH 6'h1d
`define PPCFG_IDX_POLARITY 6'h1e
`define PPCFG_IDX_IRQ_STATUS 6'h30
`define PPCFG_IDX_IRQ_MASK 6'h31

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define PPCFG_CODE_W 2
`define PPCFG_COL_HIGH_W 6
`define PPCFG_INDEX_LSB 2
`define PPCFG_INDEX_MSB 7
`define PPCFG_DECODE_TOP 8

// ----------------------------------------------------------------------
// pull selection codes
// ----------------------------------------------------------------------
`define PPCFG_PULL_UP_WEAK 2'b00
`define PPCFG_PULL_DOWN 2'b01
`define PPCFG_PULL_UP_STRONG 2'b10
`define PPCFG_PULL_NONE 2'b11

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PPCFG_RST_PULL 8'h00
`define PPCFG_RST_COL_HIGH 6'h00
`define PPCFG_RST_POLARITY 8'h00
`define PPCFG_RST_FLAG 8'h00
`define PPCFG_RST_IRQ_STATUS 8'h00
`define PPCFG_RST_IRQ_MASK 8'h00

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define PPCFG_RESP_OKAY 2'b00
`define PPCFG_RESP_SLVERR 2'b10

`endif

// File: src/ppcfg_pull_decode.v
`include "ppcfg_consts.vh"

module ppcfg_pull_decode #(
   parameter PINS = 19
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // packed pull codes, pin n at bits 2n+1:2n
   input wire [2*PINS-1:0] pull_codes,
   // per-pin resistor enables
   output reg [PINS-1:0] pull_up_weak,
   output reg [PINS-1:0] pull_down,
   output reg [PINS-1:0] pull_up_strong
);

   genvar pin;

   // one registered decoder per pin; outputs stay glitch free
   generate
      for (pin = 0; pin < PINS; pin = pin + 1) begin : g_pin
         wire [1:0] code;
         assign code = pull_codes[2*pin+1:2*pin];
         // R1: decode pull code
         always @(posedge aclk) begin
            if (!aresetn) begin
               pull_up_weak[pin] <= 1'b1;
               pull_down[pin] <= 1'b0;
               pull_up_strong[pin] <= 1'b0;
            end else begin
               pull_up_weak[pin] <= (code == `PPCFG_PULL_UP_WEAK);
               pull_down[pin] <= (code == `PPCFG_PULL_DOWN);
               pull_up_strong[pin] <= (code == `PPCFG_PULL_UP_STRONG);
            end
         end
      end
   endgenerate

endmodule // ppcfg_pull_decode

// File: sim/ppcfg_assertions.sv
module ppcfg_assertions #(
   parameter ROWS = 8,
   parameter COLS = 11
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // bus handshakes
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire rvalid,
   input wire rready,
   // pull enables
   input wire [ROWS+COLS-1:0] pull_up_weak,
   input wire [ROWS+COLS-1:0] pull_down,
   input wire [ROWS+COLS-1:0] pull_up_strong
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_pull_one_hot:
   assert property (((pull_up_weak & pull_down) | (pull_down & pull_up_strong)
      | (pull_up_weak & pull_up_strong)) == '0)
      else $error("pin with two pull enables");
   a_read_low_byte:
   assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data above low byte");
   a_read_answer:
   assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   a_write_answer:
   assert property (awvalid && awready && wvalid && wready
      |=> !awready && !wready ##1 bvalid)
      else $error("write answer late");
   a_resp_hold:
   assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rdata_hold:
   assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_resp_code:
   assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
      else $error("bad write response code");
   a_write_reopen:
   assert property (bvalid && bready |=> !bvalid ##[0:1] (awready && wready))
      else $error("write channel not reopened");
   a_read_reopen:
   assert property (rvalid && rready |=> !rvalid ##[0:1] arready)
      else $error("read channel not reopened");
   // main scenarios seen
   c_read: cover property (arvalid && arready);
   c_slverr: cover property (bvalid && bready && bresp == 2'h2);
   c_pull_down: cover property (pull_down != '0);
endmodule // ppcfg_assertions

bind ppcfg_top ppcfg_assertions #(.ROWS(ROWS), .COLS(COLS)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rvalid(rvalid), .rready(rready), .pull_up_weak(pull_up_weak),
   .pull_down(pull_down), .pull_up_strong(pull_up_strong));

// File: sim/pin_pull_and_input_level_config_bench.sv
`include "ppcfg_consts.vh"

module pin_pull_and_input_level_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   reg aclk = 1'h0;
   reg aresetn = 1'h0;
   reg [7:0] awaddr = 8'h00;
   reg [7:0] araddr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg [3:0] wstrb = 4'h0;
   reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   reg arvalid = 1'h0, rready = 1'h0;
   reg [7:0] general_input = 8'hff;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [18:0] pull_up_weak, pull_down, pull_up_strong;
   integer errors = 0, check_count = 0, cycles = 0, seed = 29360, i, k;
   reg [7:0] m [0:4];
   reg [7:0] v, p;
   reg [1:0] r;
   reg [3:0] ws = 4'hf;

   ppcfg_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .general_input(general_input),
      .pull_up_weak(pull_up_weak), .pull_down(pull_down),
      .pull_up_strong(pull_up_strong), .irq(irq));

   // 50 mhz clock
   initial forever #10 aclk = ~aclk;

   // hang guard, far above the several hundred cycles the run needs
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         end_of_test;
      end
   end

   // ----------------------------------------------------------------
   // bus tasks and comparisons
   // ----------------------------------------------------------------
   function [7:0] ad(input [5:0] x);
      ad = {x, 2'h0};
   endfunction

   // expected enable vector for one pull code over all 19 pins
   function [18:0] pf(input [1:0] code);
      reg [37:0] c;
      integer j;
      begin
         c = {m[4][5:0], m[3], m[2], m[1], m[0]};
         for (j = 0; j < 19; j = j + 1) pf[j] = (c[2*j +: 2] == code);
      end
   endfunction

   task chk(input [8*8-1:0] n, input [31:0] e, input [31:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH %0s expected %h seen %h", n, e, g);
         end
      end
   endtask

   task chkr(input [1:0] e, input [1:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH resp expected %h seen %h", e, g);
         end
      end
   endtask

   // address and data offered together, each dropped once taken
   task wrc(input [7:0] a, input [7:0] d, input [1:0] er);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= {24'h0, d};
         wstrb <= ws;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
         do begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
         end while (bvalid !== 1'h1);
         chkr(er, bresp);
         bready <= 1'h0;
      end
   endtask

   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
         do begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
         end while (rvalid !== 1'h1);
         d = rdata[7:0];
         r = rresp;
         rready <= 1'h0;
      end
   endtask

   task rdc(input [7:0] a, input [7:0] e, input [1:0] er);
      reg [7:0] d;
      begin
         rd(a, d);
         chk("rdata", e, d);
         chkr(er, r);
      end
   endtask

   // enables settle one edge after the register write; checked two edges on
   task pchk;
      begin
         repeat (2) @(posedge aclk);
         chk("weak", pf(2'h0), pull_up_weak);
         chk("down", pf(2'h1), pull_down);
         chk("strong", pf(2'h2), pull_up_strong);
      end
   endtask

   task end_of_test;
      begin
         $display("comparisons %0d errors %0d", check_count, errors);
         if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      for (k = 0; k < 6; k = k + 1) rdc(ad(6'h19 + k), 8'h00, 2'h0);
      for (k = 0; k < 5; k = k + 1) m[k] = 8'h00;
      pchk;
      // two fixed patterns put every code in each register, then random
      for (i = 0; i < 12; i = i + 1) begin
         for (k = 0; k < 5; k = k + 1) begin
            v = (i == 0) ? 8'he4 : (i == 1) ? 8'h1b : $random(seed);
            wrc(ad(6'h19 + k), v, 2'h0);
            m[k] = (k == 4) ? (v & 8'h3f) : v;
         end
         pchk;
         for (k = 0; k < 5; k = k + 1) rdc(ad(6'h19 + k), m[k], 2'h0);
      end
      // lane 0 strobe low: write answered but dropped
      ws = 4'he;
      wrc(ad(`PPCFG_IDX_ROW_LOW), ~m[0], 2'h0);
      ws = 4'hf;
      rdc(ad(`PPCFG_IDX_ROW_LOW), m[0], 2'h0);
      // unmapped place answers with an error
      wrc(8'h80, 8'h55, `PPCFG_RESP_SLVERR);
      rdc(8'h80, 8'h00, `PPCFG_RESP_SLVERR);
      // random polarity against random pin levels
      for (i = 0; i < 6; i = i + 1) begin
         v = $random(seed);
         general_input <= $random(seed);
         wrc(ad(`PPCFG_IDX_POLARITY), v, 2'h0);
         rdc(ad(`PPCFG_IDX_POLARITY), v, 2'h0);
         rdc(ad(`PPCFG_IDX_INPUT_LEVEL), general_input, 2'h0);
         rd(ad(`PPCFG_IDX_INPUT_FLAG), p);
         rdc(ad(`PPCFG_IDX_INPUT_FLAG), ~(general_input ^ v), 2'h0);
      end
      // back to quiet pins, stale flags and status drained
      wrc(ad(`PPCFG_IDX_POLARITY), 8'h00, 2'h0);
      general_input <= 8'hff;
      repeat (4) @(posedge aclk);
      rd(ad(`PPCFG_IDX_INPUT_FLAG), p);
      rdc(ad(`PPCFG_IDX_INPUT_FLAG), 8'h00, 2'h0);
      wrc(ad(`PPCFG_IDX_IRQ_STATUS), 8'hff, 2'h0);
      rdc(ad(`PPCFG_IDX_IRQ_STATUS), 8'h00, 2'h0);
      // active low input one raises the unmasked interrupt
      wrc(ad(`PPCFG_IDX_IRQ_MASK), 8'h01, 2'h0);
      general_input <= 8'hfe;
      repeat (6) @(posedge aclk);
      chk("irq", 1'h1, irq);
      general_input <= 8'hff;
      repeat (4) @(posedge aclk);
      rdc(ad(`PPCFG_IDX_INPUT_FLAG), 8'h01, 2'h0);
      rdc(ad(`PPCFG_IDX_INPUT_FLAG), 8'h00, 2'h0);
      wrc(ad(`PPCFG_IDX_IRQ_STATUS), 8'h01, 2'h0);
      repeat (2) @(posedge aclk);
      chk("irq", 1'h0, irq);
      // masked source sets status but keeps the line low
      general_input <= 8'hfd;
      repeat (6) @(posedge aclk);
      chk("irq", 1'h0, irq);
      rdc(ad(`PPCFG_IDX_IRQ_STATUS), 8'h02, 2'h0);
      end_of_test;
   end
endmodule // pin_pull_and_input_level_config_bench
